/* pkg/smt_pkg.sv */
// How it works
// - Write mode 0: chip select controls the write, data driven in pulse/hold.
// - Chip-select write: data buffers on after cs write setup, until cycle end.
// - Protect enable blocks writes to setup, pulse, cycle and mode registers.
// - A blocked write sets the violation flag and records the target register.
// - Reading the protect status register clears the violation flag.
// - Setup code is 6 bits: 128 times bit 5 plus bits 4:0.
// - Pulse code is 7 bits: 256 times bit 6 plus bits 5:0.
// - Cycle code is 9 bits: 256 times bits 8:7 plus bits 6:0.
// - Each chip select owns its setup, pulse and cycle registers.
// - Setup and pulse registers reset to 0x01010101.
// - Cycle register resets to 0x00030003, three cycles with one hold.
// - Read and write mode both reset to 1, strobe controlled.
// - Strobe write with zero hold still keeps address and cs past strobe rise.
// - Scrambling happens in line and adds no wait cycles.
// - One scrambling enable bit per chip select.
// - Scrambling uses two keys that are write-only and read as zero.
// - Idle cycles are inserted between external accesses automatically.
// - Read data captured on the edge that raises the selected strobe.
package smt_pkg;
  localparam int NUM_CS = 4;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int CNT_W = 10;
  localparam int REG_AW = 8;
  localparam int FLD_W = 8;
  localparam int CYC_W = 16;
  // Register kinds inside one chip-select block of four words.
  localparam logic [1:0] KIND_SETUP = 2'h0;
  localparam logic [1:0] KIND_PULSE = 2'h1;
  localparam logic [1:0] KIND_CYCLE = 2'h2;
  localparam logic [1:0] KIND_MODE = 2'h3;
  // Byte offsets outside the chip-select blocks.
  localparam logic [7:0] OFF_SCR_MODE = 8'h40;
  localparam logic [7:0] OFF_KEY1 = 8'h44;
  localparam logic [7:0] OFF_KEY2 = 8'h48;
  localparam logic [7:0] OFF_PROT_MODE = 8'h50;
  localparam logic [7:0] OFF_PROT_STAT = 8'h54;
  // Reset values and writable field masks.
  localparam logic [31:0] SETUP_RST = 32'h01010101;
  localparam logic [31:0] PULSE_RST = 32'h01010101;
  localparam logic [31:0] CYCLE_RST = 32'h00030003;
  localparam logic [31:0] SETUP_MASK = 32'h3f3f3f3f;
  localparam logic [31:0] PULSE_MASK = 32'h7f7f7f7f;
  localparam logic [31:0] CYCLE_MASK = 32'h01ff01ff;
  localparam logic [1:0] MODE_RST = 2'h3;
  localparam int MODE_READ_BIT = 0;
  localparam int MODE_WRITE_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : smt_pkg

/* core/smt_timing_decode.sv */
`timescale 1ns/1ps
module smt_timing_decode (
  // Raw timing words of one chip select.
  input wire logic [31:0] setup_word,
  input wire logic [31:0] pulse_word,
  input wire logic [31:0] cycle_word,
  // Effective counts in master clock cycles.
  output logic [3:0][smt_pkg::CNT_W-1:0] setup_eff,
  output logic [3:0][smt_pkg::CNT_W-1:0] pulse_eff,
  output logic [1:0][smt_pkg::CNT_W-1:0] cycle_eff
);
  import smt_pkg::*;

  // Setup code: bit 5 weighs 128.
  function automatic logic [CNT_W-1:0] dec_setup(input logic [5:0] c);
    return {2'b00, c[5], 2'b00, c[4:0]};
  endfunction : dec_setup

  // Pulse code: bit 6 weighs 256.
  function automatic logic [CNT_W-1:0] dec_pulse(input logic [6:0] c);
    return {1'b0, c[6], 2'b00, c[5:0]};
  endfunction : dec_pulse

  // Cycle code: bits 8:7 weigh 256 each step.
  function automatic logic [CNT_W-1:0] dec_cycle(input logic [8:0] c);
    return {c[8:7], 1'b0, c[6:0]};
  endfunction : dec_cycle

  // Field 0 read strobe, 1 cs read, 2 write strobe, 3 cs write.
  for (genvar i = 0; i < 4; i++) begin : g_field
    assign setup_eff[i] = dec_setup(setup_word[i*FLD_W +: 6]);
    assign pulse_eff[i] = dec_pulse(pulse_word[i*FLD_W +: 7]);
  end

  // Field 0 read total, 1 write total.
  for (genvar j = 0; j < 2; j++) begin : g_cycle
    assign cycle_eff[j] = dec_cycle(cycle_word[j*CYC_W +: 9]);
  end
endmodule : smt_timing_decode

/* core/smt_scramble.sv */
`timescale 1ns/1ps
module smt_scramble (
  // Data and access context.
  input wire logic [smt_pkg::DATA_W-1:0] data_in,
  input wire logic [smt_pkg::ADDR_W-1:0] addr,
  input wire logic [1:0] cs,
  input wire logic enable,
  // User keys.
  input wire logic [31:0] key_first,
  input wire logic [31:0] key_second,
  // Transformed data.
  output logic [smt_pkg::DATA_W-1:0] data_out
);
  import smt_pkg::*;

  logic [31:0] rot;
  logic [DATA_W-1:0] mask;

  // Mask mixes both keys, chip select and address; XOR is self-inverse.
  always_comb begin
    rot = {key_second[31:16], key_second[31:16]} >> {cs, 2'b00};
    mask = key_first[15:0] ^ key_first[31:16] ^ key_second[15:0];
    mask = mask ^ rot[15:0] ^ addr[15:0] ^ {addr[23:16], addr[23:16]};
    data_out = enable ? (data_in ^ mask) : data_in;
  end
endmodule : smt_scramble

/* core/smt_core.sv */
`timescale 1ns/1ps
module smt_core (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write channels.
  input wire logic awvalid,
  output logic awready,
  input wire logic [smt_pkg::REG_AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read channels.
  input wire logic arvalid,
  output logic arready,
  input wire logic [smt_pkg::REG_AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Access requests from the system side.
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_cs,
  input wire logic [smt_pkg::ADDR_W-1:0] req_addr,
  input wire logic [smt_pkg::DATA_W-1:0] req_wdata,
  output logic rsp_valid,
  output logic [smt_pkg::DATA_W-1:0] rsp_rdata,
  // External memory pins.
  output logic [smt_pkg::ADDR_W-1:0] mem_addr,
  output logic [smt_pkg::NUM_CS-1:0] chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [smt_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [smt_pkg::DATA_W-1:0] data_in
);
  import smt_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_EXT, ST_GAP} smt_state_t;

  logic [31:0] setup_r [NUM_CS];
  logic [31:0] pulse_r [NUM_CS];
  logic [31:0] cycle_r [NUM_CS];
  logic [1:0] mode_r [NUM_CS];
  logic protect_enable;
  logic protect_violation_flag;
  logic [7:0] protect_violation_source;
  logic [NUM_CS-1:0] cs_scramble_enable;
  logic [31:0] scramble_key_first;
  logic [31:0] scramble_key_second;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] s_q;
  logic [31:0] rd_mux;
  smt_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [1:0] acc_cs;
  logic acc_wr;
  logic [DATA_W-1:0] rd_cap;
  logic [DATA_W-1:0] data_in_s1;
  logic [DATA_W-1:0] data_in_s2;
  logic [3:0][CNT_W-1:0] s_eff;
  logic [3:0][CNT_W-1:0] p_eff;
  logic [1:0][CNT_W-1:0] c_eff;
  logic [DATA_W-1:0] scr_wdata;
  logic [DATA_W-1:0] cap_now;
  logic [DATA_W-1:0] unscr_rdata;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // Chip-select configuration words occupy offsets below 0x40.
  function automatic logic is_cfg(input logic [7:0] a);
    return a[7:6] == 2'b00;
  endfunction : is_cfg

  // Every address that answers OKAY.
  function automatic logic is_mapped(input logic [7:0] a);
    return is_cfg(a) || a == OFF_SCR_MODE || a == OFF_KEY1 ||
      a == OFF_KEY2 || a == OFF_PROT_MODE || a == OFF_PROT_STAT;
  endfunction : is_mapped

  // Byte-lane merge of a write into an old word.
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Strobe window: active from setup for pulse cycles.
  function automatic logic in_win(input logic [CNT_W-1:0] c,
                                  input logic [CNT_W-1:0] s,
                                  input logic [CNT_W-1:0] p);
    return c >= s && {1'b0, c} < ({1'b0, s} + {1'b0, p});
  endfunction : in_win

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.

  wire wr_go = aw_held && w_held && !bvalid;
  wire rd_go = arvalid && arready;
  wire [1:0] w_cs = aw_q[5:4];
  wire [1:0] w_kind = aw_q[3:2];
  wire prot_hit = wr_go && is_cfg(aw_q) && protect_enable;
  wire cfg_wr = wr_go && is_cfg(aw_q) && !protect_enable;
  wire other_wr = wr_go && !is_cfg(aw_q);

  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;

  // Address and data are caught in either order and held until used.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0;
      s_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_q <= awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_q <= wdata;
        s_q <= wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response follows the register update.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= is_mapped(aw_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Per chip-select timing and mode words, each with its own set.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CS; i++) begin
        setup_r[i] <= SETUP_RST;
        pulse_r[i] <= PULSE_RST;
        cycle_r[i] <= CYCLE_RST;
        mode_r[i] <= MODE_RST;
      end
    end else if (cfg_wr) begin
      unique case (w_kind)
        KIND_SETUP:
          setup_r[w_cs] <= wmerge(setup_r[w_cs], w_q, s_q) & SETUP_MASK;
        KIND_PULSE:
          pulse_r[w_cs] <= wmerge(pulse_r[w_cs], w_q, s_q) & PULSE_MASK;
        KIND_CYCLE:
          cycle_r[w_cs] <= wmerge(cycle_r[w_cs], w_q, s_q) & CYCLE_MASK;
        KIND_MODE:
          mode_r[w_cs] <= s_q[0] ? w_q[1:0] : mode_r[w_cs];
      endcase
    end
  end

  // Protection, scrambling enables and write-only keys.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      protect_enable <= 1'b0;
      cs_scramble_enable <= '0;
      scramble_key_first <= 32'h0;
      scramble_key_second <= 32'h0;
    end else if (other_wr && s_q[0]) begin
      if (aw_q == OFF_PROT_MODE) begin
        protect_enable <= w_q[0];
      end
      if (aw_q == OFF_SCR_MODE) begin
        cs_scramble_enable <= w_q[NUM_CS-1:0];
      end
      if (aw_q == OFF_KEY1) begin
        scramble_key_first <= w_q;
      end
      if (aw_q == OFF_KEY2) begin
        scramble_key_second <= w_q;
      end
    end
  end

  // Violation flag: a new violation wins over the clearing read.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      protect_violation_flag <= 1'b0;
      protect_violation_source <= 8'h00;
    end else if (prot_hit) begin
      protect_violation_flag <= 1'b1;
      protect_violation_source <= aw_q;
    end else if (rd_go && araddr == OFF_PROT_STAT) begin
      protect_violation_flag <= 1'b0;
    end
  end

  // Read data selection; keys and unmapped words read as zero.
  always_comb begin
    rd_mux = 32'h0;
    if (is_cfg(araddr)) begin
      unique case (araddr[3:2])
        KIND_SETUP: rd_mux = setup_r[araddr[5:4]];
        KIND_PULSE: rd_mux = pulse_r[araddr[5:4]];
        KIND_CYCLE: rd_mux = cycle_r[araddr[5:4]];
        KIND_MODE: rd_mux = {30'h0, mode_r[araddr[5:4]]};
      endcase
    end else if (araddr == OFF_SCR_MODE) begin
      rd_mux = {28'h0, cs_scramble_enable};
    end else if (araddr == OFF_PROT_MODE) begin
      rd_mux = {31'h0, protect_enable};
    end else if (araddr == OFF_PROT_STAT) begin
      rd_mux = {16'h0, protect_violation_source, 7'h0,
                protect_violation_flag};
    end
  end

  // Read answer one cycle after the address is taken.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External access engine.

  smt_timing_decode u_decode (
    .setup_word(setup_r[acc_cs]),
    .pulse_word(pulse_r[acc_cs]),
    .cycle_word(cycle_r[acc_cs]),
    .setup_eff(s_eff),
    .pulse_eff(p_eff),
    .cycle_eff(c_eff)
  );

  smt_scramble u_scr_wr (
    .data_in(req_wdata),
    .addr(req_addr),
    .cs(req_cs),
    .enable(cs_scramble_enable[req_cs]),
    .key_first(scramble_key_first),
    .key_second(scramble_key_second),
    .data_out(scr_wdata)
  );

  smt_scramble u_scr_rd (
    .data_in(cap_now),
    .addr(mem_addr),
    .cs(acc_cs),
    .enable(cs_scramble_enable[acc_cs]),
    .key_first(scramble_key_first),
    .key_second(scramble_key_second),
    .data_out(unscr_rdata)
  );

  wire wmode = mode_r[acc_cs][MODE_WRITE_BIT];
  wire rmode = mode_r[acc_cs][MODE_READ_BIT];
  wire [CNT_W-1:0] total = acc_wr ? c_eff[1] : c_eff[0];
  wire last = ({1'b0, cnt} + 11'd1) >= {1'b0, total};
  wire [CNT_W:0] we_end = {1'b0, s_eff[2]} + {1'b0, p_eff[2]};
  wire we_hold0 = we_end >= {1'b0, c_eff[1]};
  wire go_ext = acc_wr && wmode && we_hold0;
  wire [CNT_W-1:0] rd_end = rmode ? CNT_W'(s_eff[0] + p_eff[0])
                                  : CNT_W'(s_eff[1] + p_eff[1]);
  wire cap_hit = state == ST_ACC && !acc_wr && cnt == rd_end;
  assign cap_now = cap_hit ? data_in_s2 : rd_cap;
  assign req_ready = state == ST_IDLE;

  // Read data pins pass two flip-flops before use.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_in_s1 <= '0;
      data_in_s2 <= '0;
    end else begin
      data_in_s1 <= data_in;
      data_in_s2 <= data_in_s1;
    end
  end

  // Sequencer: access, optional address hold, then one idle cycle.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      acc_cs <= 2'h0;
      acc_wr <= 1'b0;
      mem_addr <= '0;
      data_out <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (req_valid) begin
            state <= ST_ACC;
            cnt <= '0;
            acc_cs <= req_cs;
            acc_wr <= req_write;
            mem_addr <= req_addr;
            data_out <= scr_wdata;
          end
        end
        ST_ACC: begin
          if (last) begin
            state <= go_ext ? ST_EXT : ST_GAP;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_EXT: state <= ST_GAP;
        ST_GAP: state <= ST_IDLE;
      endcase
    end
  end

  // Read capture on the edge that raises the controlling strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_cap <= '0;
    end else if (cap_hit) begin
      rd_cap <= data_in_s2;
    end
  end

  // Strobe and buffer pins, registered from the cycle count.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chip_select_n <= '1;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      data_oe <= 1'b0;
    end else begin
      chip_select_n <= '1;
      if ((state == ST_ACC && (acc_wr ? in_win(cnt, s_eff[3], p_eff[3])
           : in_win(cnt, s_eff[1], p_eff[1]))) || state == ST_EXT) begin
        chip_select_n <= ~(4'h1 << acc_cs);
      end
      read_strobe_n <= !(state == ST_ACC && !acc_wr &&
                         in_win(cnt, s_eff[0], p_eff[0]));
      write_strobe_n <= !(state == ST_ACC && acc_wr &&
                          in_win(cnt, s_eff[2], p_eff[2]));
      data_oe <= acc_wr && ((state == ST_ACC &&
                 cnt >= (wmode ? s_eff[2] : s_eff[3])) ||
                 state == ST_EXT);
    end
  end

  // Completion pulse with unscrambled read data.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state == ST_ACC && last && !go_ext) ||
                   state == ST_EXT;
      if (state == ST_ACC && last && !acc_wr) begin
        rsp_rdata <= unscr_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_prot_blocks_cfg: assert property (
    prot_hit && w_cs == 2'h0 |=> $stable(setup_r[0]) &&
      $stable(pulse_r[0]) && $stable(cycle_r[0]) && $stable(mode_r[0]))
    else $error("protected register changed");

  a_violation_source: assert property (
    prot_hit |=> protect_violation_flag &&
      protect_violation_source == $past(aw_q))
    else $error("violation not recorded");

  a_status_read_clear: assert property (
    rd_go && araddr == OFF_PROT_STAT && !prot_hit
      |=> !protect_violation_flag ##1 rvalid || !protect_violation_flag)
    else $error("violation flag not cleared by read");

  a_reset_timing: assert property (
    $fell(rst) |-> setup_r[1] == SETUP_RST && pulse_r[2] == PULSE_RST &&
      cycle_r[3] == CYCLE_RST && mode_r[0] == MODE_RST)
    else $error("timing reset value wrong");

  a_cs_write_oe: assert property (
    state == ST_ACC && acc_wr && !wmode && cnt >= s_eff[3] |=> data_oe)
    else $error("buffers off in cs write");

  a_keys_hidden: assert property (
    rd_go && (araddr == OFF_KEY1 || araddr == OFF_KEY2)
      |=> rvalid && rdata == 32'h0)
    else $error("key readable");

  a_idle_gap: assert property (
    state == ST_GAP |=> &chip_select_n && read_strobe_n &&
      write_strobe_n && state == ST_IDLE)
    else $error("no idle cycle");

  a_zero_hold_ext: assert property (
    state == ST_ACC && last && go_ext
      |=> state == ST_EXT ##1 chip_select_n != 4'hf && write_strobe_n)
    else $error("cs not held past write strobe");

  a_read_capture: assert property (
    cap_hit |=> rd_cap == $past(data_in_s2))
    else $error("read capture missed");

  c_write_access: cover property (state == ST_ACC && acc_wr && last);
  c_read_access: cover property (state == ST_ACC && !acc_wr && cap_hit);
  c_violation: cover property (prot_hit);
  c_hold_ext: cover property (state == ST_EXT);
endmodule : smt_core

/* verification/smt_mem_model.sv */
`timescale 1ns/1ps
module smt_mem_model
  import smt_pkg::*;
(
  // Clock.
  input wire logic ref_clk,
  // Pins from the controller.
  input wire logic [smt_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [smt_pkg::NUM_CS-1:0] chip_select_n,
  input wire logic read_strobe_n,
  input wire logic [smt_pkg::DATA_W-1:0] data_out,
  input wire logic data_oe,
  // Data back to the controller.
  output logic [smt_pkg::DATA_W-1:0] data_in
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] junk = 16'h5a5a;
  ////////////////////////////////////////////////////////////////////////////
  // Stores driven data while selected; the last driven word wins.
  always_ff @(posedge ref_clk) begin
    if (data_oe && chip_select_n != 4'hf) begin
      mem[mem_addr[3:0]] <= data_out;
    end
    junk <= junk + 16'h3b1;
  end
  // Drives the word while selected for a read, a moving pattern otherwise.
  always_comb begin
    if (chip_select_n != 4'hf && !read_strobe_n && !data_oe) begin
      data_in = mem[mem_addr[3:0]];
    end else begin
      data_in = junk;
    end
  end
endmodule : smt_mem_model

/* verification/static_memory_timing_protect_scramble_tb.sv */
`timescale 1ns/1ps
module static_memory_timing_protect_scramble_tb;
  import smt_pkg::*;
  logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, req_valid, req_ready, req_write;
  logic rsp_valid, read_strobe_n, write_strobe_n, data_oe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, chip_select_n;
  logic [1:0] bresp, rresp, req_cs;
  logic [23:0] req_addr, mem_addr;
  logic [15:0] req_wdata, rsp_rdata, data_out, data_in, q;
  int err_total, compares, lw0, f0, lw1, low, fst, lat;
  smt_core smt_core_inst (.ref_clk(ref_clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_cs(req_cs), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in));
  smt_mem_model smt_mem_model_inst (.ref_clk(ref_clk), .mem_addr(mem_addr),
    .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .data_out(data_out), .data_oe(data_oe), .data_in(data_in));
  ////////////////////////////////////////////////////////////////////////////
  // Clock generator.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compares one value.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Register write over the bus.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk(bresp, r);
  endtask : wr
  // Register read over the bus, compared with an expected word and code.
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r = RESP_OKAY);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(rdata, e);
    chk(rresp, r);
  endtask : rd
  // One memory access; returns data, latency, select low count and start.
  task automatic acc(input logic w, input logic [1:0] cs, input logic [3:0] a,
                     input logic [15:0] d);
    lat = 0;
    low = 0;
    fst = -1;
    req_valid <= 1'b1;
    req_write <= w;
    req_cs <= cs;
    req_addr <= {20'h0, a};
    req_wdata <= d;
    do @(posedge ref_clk); while (!req_ready);
    req_valid <= 1'b0;
    while (!rsp_valid) begin
      @(posedge ref_clk);
      lat++;
      if (!chip_select_n[cs]) begin
        low++;
        if (fst < 0) fst = lat;
      end
    end
    q = rsp_rdata;
  endtask : acc
  // Reset values and an unmapped place, read and written.
  task automatic t_reset;
    rd(8'h00, SETUP_RST);
    rd(8'h04, PULSE_RST);
    rd(8'h08, CYCLE_RST);
    rd(8'h0c, 32'h3);
    rd(8'h38, CYCLE_RST);
    rd(8'hfc, 32'h0, RESP_SLVERR);
    wr(8'hfc, 32'h0, RESP_SLVERR);
  endtask : t_reset
  // Long coded timings on one select against defaults on another.
  task automatic t_timing;
    acc(1'b1, 2'h0, 4'h1, 16'h1234);
    lw0 = lat;
    f0 = fst;
    chk(smt_mem_model_inst.mem[1], 16'h1234);
    wr(8'h10, 32'h21010101);
    wr(8'h14, 32'h41010505);
    wr(8'h18, 32'h01830007);
    wr(8'h1c, 32'h1);
    rd(8'h10, 32'h21010101);
    rd(8'h14, 32'h41010505);
    rd(8'h18, 32'h01830007);
    rd(8'h00, SETUP_RST);
    acc(1'b1, 2'h1, 4'h2, 16'hbeef);
    lw1 = lat;
    chk(lat, lw0 + 768);
    chk(low, 257);
    chk(fst, f0 + 128);
    chk(smt_mem_model_inst.mem[2], 16'hbeef);
    acc(1'b0, 2'h1, 4'h2, 16'h0);
    chk(q, 16'hbeef);
  endtask : t_timing
  // Strobe write with no hold keeps the select one more cycle.
  task automatic t_zero_hold;
    wr(8'h28, 32'h00020003);
    acc(1'b1, 2'h2, 4'h5, 16'h7e81);
    chk(lat, 4);
    chk(low, 2);
    chk(smt_mem_model_inst.mem[5], 16'h7e81);
  endtask : t_zero_hold
  // Scrambling on one select only, with write-only keys.
  task automatic t_scramble;
    wr(OFF_KEY1, 32'hc3a51e0f);
    wr(OFF_KEY2, 32'h0f1ea5c3);
    wr(OFF_SCR_MODE, 32'h2);
    rd(OFF_KEY1, 32'h0);
    rd(OFF_KEY2, 32'h0);
    acc(1'b1, 2'h1, 4'h3, 16'h5aa5);
    chk(lat, lw1);
    chk(smt_mem_model_inst.mem[3] !== 16'h5aa5, 1);
    acc(1'b0, 2'h1, 4'h3, 16'h0);
    chk(q, 16'h5aa5);
    acc(1'b1, 2'h0, 4'h4, 16'h0f0f);
    chk(smt_mem_model_inst.mem[4], 16'h0f0f);
  endtask : t_scramble
  // Blocked writes, violation record and clear on read.
  task automatic t_protect;
    wr(OFF_PROT_MODE, 32'h1);
    wr(8'h00, 32'h02020202);
    rd(8'h00, SETUP_RST);
    wr(8'h0c, 32'h0);
    rd(8'h0c, 32'h3);
    rd(OFF_PROT_STAT, 32'h0c01);
    rd(OFF_PROT_STAT, 32'h0c00);
    wr(OFF_PROT_MODE, 32'h0);
    wr(8'h00, 32'h02020202);
    rd(8'h00, 32'h02020202);
    rd(OFF_PROT_STAT, 32'h0c00);
  endtask : t_protect
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  // Main sequence.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, req_valid, req_write} = '0;
    {awaddr, araddr, wdata, req_cs, req_addr, req_wdata} = '0;
    wstrb = 4'hf;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_timing();
    t_zero_hold();
    t_scramble();
    t_protect();
    give_verdict();
  end
endmodule : static_memory_timing_protect_scramble_tb
